/* dfl_defines.vh */
`ifndef DFL_DEFINES_VH
`define DFL_DEFINES_VH
// =====================================================
// Command encodings {cs_n, ras_n, cas_n, we_n}
`define DFL_CMD_MODE_WR 4'h0
`define DFL_CMD_SRE 4'h1
// =====================================================
// Mode register field positions
`define DFL_MODE_ONE_DLL_DIS_BIT 0
`define DFL_MODE_ONE_WLVL_BIT 7
`define DFL_MODE_ONE_QOFF_BIT 12
`define DFL_MODE_ZERO_DLL_RST_BIT 8
`define DFL_MODE_ONE_TERM_MASK 16'h0244
`define DFL_MODE_TWO_TERM_MASK 16'h0600
// =====================================================
// Timing figures
`define DFL_CLK_NS 50
`define DFL_LOCK_NCK 512
`define DFL_WLO_NS 9
`define DFL_CKSRE_NS 100
`endif

/* dfl_sync.v */
`timescale 1ns/1ns
// =====================================================
// Two-flop synchroniser for pin inputs
module dfl_sync #(
  parameter W = 1
) (
  // Clock, reset, enable
  input wire i_clk,
  input wire i_resetn,
  input wire i_ce,
  // Data
  input wire [W-1:0] i_d,
  output wire [W-1:0] o_q
);
  reg [W-1:0] meta_q; // First stage, read only by second
  reg [W-1:0] sync_q; // Second stage
  // Two stages, frozen with the clock enable
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_q <= {W{1'b0}};
      sync_q <= {W{1'b0}};
    end else if (i_ce) begin
      meta_q <= i_d;
      sync_q <= meta_q;
    end
  end
  assign o_q = sync_q;
endmodule

/* dfl_core.v */
`timescale 1ns/1ns
`include "dfl_defines.vh"
// =====================================================
// Loop, frequency change and write leveling sequencer
module dfl_core #(
  parameter DQ_W = 16,
  parameter PRIME_ONLY = 1,
  parameter LOCK_NCK = `DFL_LOCK_NCK
) (
  // Clock, reset, enable
  input wire i_clk,
  input wire i_resetn,
  input wire i_ce,
  // Memory link pins (asynchronous to i_clk)
  input wire i_mem_clk,
  input wire i_cke,
  input wire [3:0] i_cmd,
  input wire [2:0] i_ba,
  input wire [15:0] i_addr,
  input wire i_termination_control_input,
  input wire i_upper_lane_strobe,
  input wire i_lower_lane_strobe,
  // Data pins
  output reg [DQ_W-1:0] o_dq,
  output wire [DQ_W-1:0] o_dq_oe,
  // Termination enables
  output wire o_strobe_term_en,
  output wire o_dq_term_en,
  // Status
  output wire o_loop_locked,
  output wire o_self_refresh,
  output wire o_leveling,
  output wire o_outbuf_off,
  output wire o_clock_ignored
);
  // =====================================================
  // Timing counts
  localparam WLO_CYC = (`DFL_WLO_NS + `DFL_CLK_NS - 1) / `DFL_CLK_NS;
  localparam HOLD_CYC = (`DFL_CKSRE_NS + `DFL_CLK_NS - 1) / `DFL_CLK_NS;
  localparam [2:0] WLO_C = WLO_CYC[2:0];
  localparam [3:0] HOLD_C = HOLD_CYC[3:0];
  localparam [15:0] LOCK_C = LOCK_NCK[15:0];
  localparam HALF = DQ_W / 2;

  // =====================================================
  // States of the link, one-hot
  localparam [2:0] ST_IDLE = 3'h1;
  localparam [2:0] ST_SREF = 3'h2;
  localparam [2:0] ST_PDWN = 3'h4;

  // Synchronised pins
  wire mclk_s, cke_s, term_s, us_s, ls_s;
  wire [3:0] cmd_s;
  wire [2:0] ba_s;
  wire [15:0] addr_s;
  dfl_sync #(.W(28)) u_sync (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_ce(i_ce),
    .i_d({i_mem_clk, i_cke, i_termination_control_input, i_upper_lane_strobe,
          i_lower_lane_strobe, i_cmd, i_ba, i_addr}),
    .o_q({mclk_s, cke_s, term_s, us_s, ls_s, cmd_s, ba_s, addr_s})
  );

  // =====================================================
  // Edge history and sequencer registers
  reg mclk_q, us_q, ls_q, cke_q;
  reg [2:0] state_q;
  reg dll_en_q; // Loop enable from mode one bit 0
  reg locked_q; // Loop lock reached
  reg [15:0] lock_cnt_q; // Link clocks left until lock
  reg wlvl_q; // Leveling mode
  reg qoff_q; // Output buffers disabled
  reg term_q; // Any termination feature enabled
  reg [3:0] hold_cnt_q; // Self-refresh hold timer
  reg up_smp_q, lo_smp_q; // Clock samples per lane
  reg fb_pend_q; // Feedback pending after strobe
  reg [2:0] wlo_cnt_q; // Feedback delay counter
  reg up_fb_q, lo_fb_q; // Published feedback
  reg drive_q; // Feedback drive started

  wire mclk_rise = mclk_s & ~mclk_q;
  wire us_rise = us_s & ~us_q;
  wire ls_rise = ls_s & ~ls_q;
  // Commands taken on the memory clock rising edge with clock enable high
  wire cmd_take = mclk_rise & cke_s & (state_q == ST_IDLE);
  wire is_mode_wr = cmd_take & (cmd_s == `DFL_CMD_MODE_WR);
  wire is_sre = cmd_take & (cmd_s == `DFL_CMD_SRE);
  wire mode_zero_wr = is_mode_wr & (ba_s == 3'h0);
  wire mode_one_wr = is_mode_wr & (ba_s == 3'h1);
  wire mode_two_wr = is_mode_wr & (ba_s == 3'h2);

  // =====================================================
  // Power state: self-refresh and power-down tracking
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      mclk_q <= 1'b0;
      us_q <= 1'b0;
      ls_q <= 1'b0;
      cke_q <= 1'b0;
      state_q <= ST_IDLE;
      hold_cnt_q <= 4'h0;
    end else if (i_ce) begin
      mclk_q <= mclk_s;
      us_q <= us_s;
      ls_q <= ls_s;
      cke_q <= cke_s;
      case (state_q)
        ST_IDLE: begin
          if (is_sre) begin
            state_q <= ST_SREF;
            hold_cnt_q <= HOLD_C;
          end else if (cke_q & ~cke_s) begin
            state_q <= ST_PDWN; // Clock may change after hold
          end
        end
        ST_SREF: begin
          // Clock ignored once hold time passes
          if (hold_cnt_q != 4'h0)
            hold_cnt_q <= hold_cnt_q - 4'h1;
          // Enable is still high with the entry command; leave on its next rise
          if (cke_s & ~cke_q)
            state_q <= ST_IDLE;
        end
        ST_PDWN: begin
          if (cke_s)
            state_q <= ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // =====================================================
  // Mode register decode and loop lock timer
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dll_en_q <= 1'b1;
      locked_q <= 1'b0;
      lock_cnt_q <= 16'h0;
      wlvl_q <= 1'b0;
      qoff_q <= 1'b0;
      term_q <= 1'b0;
    end else if (i_ce) begin
      if (mode_one_wr) begin
        dll_en_q <= ~addr_s[`DFL_MODE_ONE_DLL_DIS_BIT];
        wlvl_q <= addr_s[`DFL_MODE_ONE_WLVL_BIT];
        qoff_q <= addr_s[`DFL_MODE_ONE_QOFF_BIT];
        term_q <= |(addr_s & `DFL_MODE_ONE_TERM_MASK);
        if (addr_s[`DFL_MODE_ONE_DLL_DIS_BIT])
          locked_q <= 1'b0;
      end else if (mode_two_wr && (addr_s & `DFL_MODE_TWO_TERM_MASK) != 16'h0) begin
        term_q <= 1'b1;
      end
      // Loop reset restarts the lock count
      if (mode_zero_wr && addr_s[`DFL_MODE_ZERO_DLL_RST_BIT] && dll_en_q) begin
        locked_q <= 1'b0;
        lock_cnt_q <= LOCK_C;
      end else if (mclk_rise && lock_cnt_q != 16'h0) begin
        // Counts link clocks; controller keeps clock enable high
        lock_cnt_q <= lock_cnt_q - 16'h1;
        if (lock_cnt_q == 16'h1)
          locked_q <= 1'b1;
      end else if (state_q != ST_IDLE) begin
        // Frequency change invalidates lock until next reset
        locked_q <= 1'b0;
      end
    end
  end

  // =====================================================
  // Leveling: sample clock on strobe rise, publish after delay
  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      up_smp_q <= 1'b0;
      lo_smp_q <= 1'b0;
      fb_pend_q <= 1'b0;
      wlo_cnt_q <= 3'h0;
      up_fb_q <= 1'b0;
      lo_fb_q <= 1'b0;
      drive_q <= 1'b0;
    end else if (i_ce) begin
      if (!wlvl_q) begin
        fb_pend_q <= 1'b0;
        drive_q <= 1'b0;
        up_fb_q <= 1'b0;
        lo_fb_q <= 1'b0;
      end else begin
        // Each lane samples with its own strobe
        if (us_rise)
          up_smp_q <= mclk_s;
        if (ls_rise)
          lo_smp_q <= mclk_s;
        if (us_rise | ls_rise) begin
          fb_pend_q <= 1'b1;
          wlo_cnt_q <= WLO_C;
        end else if (fb_pend_q) begin
          if (wlo_cnt_q > 3'h1) begin
            wlo_cnt_q <= wlo_cnt_q - 3'h1;
          end else begin
            fb_pend_q <= 1'b0; // Feedback after delay
            up_fb_q <= up_smp_q;
            lo_fb_q <= lo_smp_q;
            drive_q <= 1'b1;
          end
        end
      end
    end
  end

  // =====================================================
  // Data pin drive: prime bit per lane or all bits
  integer k;
  always @* begin
    o_dq = {DQ_W{1'b0}};
    for (k = 0; k < DQ_W; k = k + 1) begin
      if (PRIME_ONLY == 0 || k == 0 || k == HALF)
        o_dq[k] = (k >= HALF) ? up_fb_q : lo_fb_q;
    end
  end
  assign o_dq_oe = {DQ_W{wlvl_q & drive_q & ~qoff_q}};

  // Leveling: termination control switches strobe pair only
  assign o_strobe_term_en = term_s & term_q & (state_q == ST_IDLE);
  assign o_dq_term_en = term_s & term_q & ~wlvl_q & (state_q == ST_IDLE);
  assign o_loop_locked = locked_q;
  assign o_self_refresh = state_q[1];
  assign o_leveling = wlvl_q;
  assign o_outbuf_off = qoff_q;
  assign o_clock_ignored = state_q[1] & (hold_cnt_q == 4'h0);
endmodule

/* dfl_core_checker.sv */
`timescale 1ns/1ns
// =====
// Port checker for the loop and leveling sequencer
module dfl_core_checker #(
  parameter DQ_W = 16,
  parameter PRIME_ONLY = 1
) (
  // Clock and reset
  input wire i_clk,
  input wire i_resetn,
  // Observed pins
  input wire i_termination_control_input,
  input wire [DQ_W-1:0] o_dq,
  input wire [DQ_W-1:0] o_dq_oe,
  input wire o_strobe_term_en,
  input wire o_dq_term_en,
  input wire o_loop_locked,
  input wire o_self_refresh,
  input wire o_leveling,
  input wire o_outbuf_off,
  input wire o_clock_ignored
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  a_oe_whole_bus: assert property (o_dq_oe != 0 |-> &o_dq_oe)
    else $error("partial data drive");
  a_spare_bits_low: assert property (o_leveling && PRIME_ONLY != 0 |-> o_dq[DQ_W/2-1:1] == 0
    && o_dq[DQ_W-1:DQ_W/2+1] == 0) else $error("spare data bit high");
  a_exit_stops_drive: assert property ($fell(o_leveling) |-> ##[0:1] o_dq_oe == 0)
    else $error("drive after leveling exit");
  a_qoff_stops_drive: assert property ($rose(o_outbuf_off) |-> ##[0:1] o_dq_oe == 0)
    else $error("drive with buffers off");
  a_strobe_term_follow: assert property ((o_leveling && i_termination_control_input)[*6]
    |-> o_strobe_term_en) else $error("strobe termination off");
  a_dq_term_off: assert property (o_leveling |-> !o_dq_term_en)
    else $error("data termination while leveling");
  a_lock_takes_time: assert property ($rose(o_loop_locked) |-> !$past(o_loop_locked, 50))
    else $error("lock too early");
  a_ignore_after_hold: assert property ($rose(o_clock_ignored) |-> $past(o_self_refresh, 2))
    else $error("clock ignored too soon");
endmodule
bind dfl_core dfl_core_checker #(.DQ_W(DQ_W), .PRIME_ONLY(PRIME_ONLY)) u_chk (.i_clk(i_clk),
  .i_resetn(i_resetn),
  .i_termination_control_input(i_termination_control_input), .o_dq(o_dq), .o_dq_oe(o_dq_oe),
  .o_strobe_term_en(o_strobe_term_en), .o_dq_term_en(o_dq_term_en),
  .o_loop_locked(o_loop_locked), .o_self_refresh(o_self_refresh), .o_leveling(o_leveling),
  .o_outbuf_off(o_outbuf_off), .o_clock_ignored(o_clock_ignored));

/* dfl_ctrl_model.sv */
`timescale 1ns/1ns
// =====
// Memory controller model: clock, commands, strobes
module dfl_ctrl_model (
  output logic o_mem_clk,
  output logic o_cke,
  output logic [3:0] o_cmd,
  output logic [2:0] o_ba,
  output logic [15:0] o_addr,
  output logic o_term_ctl,
  output logic o_ups,
  output logic o_lows
);
  logic run = 1'b1; // Low parks the clock for a strobe sample
  int half_ns = 200; // Half period, changed only in self-refresh or power-down
  // Stable free-running clock, 400 ns period unless the bench changes it
  initial begin
    {o_mem_clk, o_ups, o_lows, o_term_ctl, o_cke} = 5'h01;
    o_cmd = 4'hF; // Deselect while idle
    o_ba = 3'h0;
    o_addr = 16'h0000;
    forever #(half_ns) if (run) o_mem_clk = ~o_mem_clk;
  end
  // One command held across a rise, then released and spaced
  task issue(input logic [3:0] c, input logic [2:0] b, input logic [15:0] a);
    @(negedge o_mem_clk);
    {o_cmd, o_ba, o_addr} = {c, b, a};
    @(negedge o_mem_clk);
    {o_cmd, o_ba, o_addr} = {4'hF, ~b, ~a}; // Released bus shows no stale value
    @(negedge o_mem_clk); // Command spacing
  endtask
  // Park clock at ck, then one rising edge on the chosen strobe
  task sample(input logic ck, input logic up);
    run = 1'b0;
    #400 o_mem_clk = ck;
    #400 if (up) o_ups = 1'b1; else o_lows = 1'b1; // Single edge per step
    #400 {o_ups, o_lows, run} = 3'h1;
  endtask
  // Termination control and clock enable, changed away from the clock rise
  task pins(input logic term, input logic ce);
    @(negedge o_mem_clk);
    {o_term_ctl, o_cke} = {term, ce};
  endtask
endmodule

/* dfl_core_tb_top.sv */
`timescale 1ns/1ns
// =====
// Bench for the loop and leveling sequencer
module dfl_core_tb_top;
  logic i_clk;
  logic i_resetn;
  wire mclk, cke, term_ctl, ups, lows, st_term, dq_term, lock, sr, lvl, qoff, ign;
  wire [3:0] cmd;
  wire [2:0] ba;
  wire [15:0] addr, dq, oe;
  int mismatches = 0;
  int samples_checked = 0;
  dfl_ctrl_model u_ctrl (.o_mem_clk(mclk), .o_cke(cke), .o_cmd(cmd), .o_ba(ba), .o_addr(addr),
    .o_term_ctl(term_ctl), .o_ups(ups), .o_lows(lows));
  dfl_core #(.DQ_W(16), .PRIME_ONLY(1), .LOCK_NCK(8)) uut (.i_clk(i_clk), .i_resetn(i_resetn),
    .i_ce(1'b1), .i_mem_clk(mclk), .i_cke(cke), .i_cmd(cmd), .i_ba(ba), .i_addr(addr),
    .i_termination_control_input(term_ctl), .i_upper_lane_strobe(ups),
    .i_lower_lane_strobe(lows),
    .o_dq(dq), .o_dq_oe(oe), .o_strobe_term_en(st_term), .o_dq_term_en(dq_term),
    .o_loop_locked(lock), .o_self_refresh(sr), .o_leveling(lvl), .o_outbuf_off(qoff),
    .o_clock_ignored(ign));
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  // Compare one value, report at once
  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // Watchdog, several times the expected run
  initial begin
    #100000 mismatches++;
    print_verdict();
  end
  initial begin
    i_resetn = 1'b0;
    repeat (2) @(posedge i_clk);
    @(negedge i_clk) i_resetn = 1'b1;
    check("reset status", {lock, lvl, sr, qoff, ign}, 16'h0000);
    check("reset drive", oe, 16'h0000);
    $display("reset test done");
    u_ctrl.issue(4'h0, 3'h1, 16'h0000); // Loop enable
    u_ctrl.issue(4'h0, 3'h0, 16'h0100); // Loop reset
    check("lock early", lock, 16'h0000);
    for (int n = 0; n < 400 && lock !== 1'b1; n++) @(negedge i_clk);
    check("lock", lock, 16'h0001);
    $display("lock test done");
    u_ctrl.issue(4'h0, 3'h1, 16'h0084); // Leveling on, termination enabled
    set_term(1'b1);
    check("leveling", lvl, 16'h0001);
    check("terms", {st_term, dq_term}, 16'h0002);
    check("drive before sample", oe, 16'h0000);
    u_ctrl.sample(1'b1, 1'b0);
    check("lower high", dq, 16'h0001);
    check("drive", oe, 16'hFFFF);
    u_ctrl.sample(1'b0, 1'b0);
    check("lower low", dq, 16'h0000);
    u_ctrl.sample(1'b1, 1'b1);
    check("upper lane", dq, 16'h0100);
    set_term(1'b0);
    check("terms off", {st_term, dq_term}, 16'h0000);
    u_ctrl.issue(4'h0, 3'h1, 16'h1084); // Only the buffer bit changes
    check("qoff drive", oe, 16'h0000);
    check("qoff bit", qoff, 16'h0001);
    check("qoff level", lvl, 16'h0001);
    u_ctrl.issue(4'h0, 3'h1, 16'h0000);
    check("exit", {lvl, qoff}, 16'h0000);
    check("exit drive", oe, 16'h0000);
    $display("leveling test done");
    u_ctrl.issue(4'h1, 3'h0, 16'h0000); // Idle, banks closed, termination low
    u_ctrl.pins(1'b0, 1'b0); // Enable low keeps self-refresh
    repeat (6) @(negedge i_clk);
    check("refresh", {sr, ign}, 16'h0003);
    check("refresh lock", lock, 16'h0000);
    u_ctrl.half_ns = 150; // New stable rate inside the operating range
    u_ctrl.issue(4'h0, 3'h1, 16'h1000);
    check("refused", qoff, 16'h0000);
    u_ctrl.pins(1'b0, 1'b1); // Exit; enable high, termination low until lock
    repeat (6) @(negedge i_clk);
    check("refresh exit", sr, 16'h0000);
    u_ctrl.issue(4'h0, 3'h1, 16'h0000); // Loop enable after exit delay
    u_ctrl.issue(4'h0, 3'h0, 16'h0100); // Loop reset
    u_ctrl.issue(4'h0, 3'h2, 16'h0008); // Latency rewrite
    check("relock early", lock, 16'h0000);
    for (int n = 0; n < 400 && lock !== 1'b1; n++) @(negedge i_clk);
    check("relock", lock, 16'h0001);
    $display("refresh test done");
    u_ctrl.pins(1'b0, 1'b0); // Power-down, controls held low
    repeat (6) @(negedge i_clk); // Hold time before the rate changes
    u_ctrl.half_ns = 200; // Back to the first rate
    check("power-down lock", lock, 16'h0000);
    check("power-down state", sr, 16'h0000);
    repeat (16) @(negedge i_clk); // Stable clock before exit
    u_ctrl.pins(1'b0, 1'b1); // Enable high, termination low while relocking
    u_ctrl.issue(4'h0, 3'h0, 16'h0100); // Loop reset after exit
    for (int n = 0; n < 400 && lock !== 1'b1; n++) @(negedge i_clk);
    check("power-down relock", lock, 16'h0001);
    $display("power-down test done");
    print_verdict();
  end
  // Termination level changed away from the memory clock rise
  task set_term(input logic v);
    u_ctrl.pins(v, 1'b1);
    repeat (8) @(negedge i_clk);
  endtask
endmodule
